// >>> dv/ce_link_props.sv
// Checker for the link between the CRC engine and its controller.
// Assumes one clock, async active-low reset, and sees only link signals.
`timescale 1ns/10ps
module ce_link_props
    import ce_pkg::*;
(
    // Clock and reset
    input wire logic        hclk,
    input wire logic        hresetn,
    // Link signals
    input wire logic        req,
    input wire logic        wr,
    input wire logic [1:0]  idx,
    input wire logic [1:0]  size,
    input wire logic [31:0] wdata,
    input wire logic [31:0] rdata,
    input wire logic        ack,
    input wire logic        dma_req
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic       en_q;
    logic       dma_q;
    logic [5:0] cnt;
    ////////////////////////////////////////////////////////////////
    // Shadow of enables and busy time; refused writes do not count
    wire       acc      = req && wr && idx == 2'h1 && en_q && cnt == 6'h00;
    wire       rd_ctl   = req && !wr && idx == 2'h0;
    wire       gate     = en_q && dma_q;
    wire [5:0] nbits    = size == CE_SZ_BYTE ? 6'h08 : (size == CE_SZ_HALF ? 6'h10 : 6'h20);
    wire [5:0] next_cnt = acc ? nbits : ((cnt != 6'h00) ? cnt - 6'h01 : cnt);
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q  <= 1'h0;
            dma_q <= 1'h0;
            cnt   <= 6'h00;
        end else begin
            if (req && wr && idx == 2'h0) begin
                en_q  <= wdata[CE_B_EN];
                dma_q <= wdata[CE_B_DMA];
            end
            cnt <= next_cnt;
        end
    end
    ////////////////////////////////////////////////////////////////
    // Steps of a data transfer
    sequence s_dw;
        acc;
    endsequence
    sequence s_quiet;
        (!dma_req) [*8];
    endsequence
    property p_ack_after_req;
        req |=> ack;
    endproperty
    a_ack_after_req: assert property (p_ack_after_req) else $error("ack missing after request");
    property p_ack_cause;
        ack |-> $past(req);
    endproperty
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    property p_port_wo;
        req && !wr && idx == 2'h1 |=> rdata == 32'h0;
    endproperty
    a_port_wo: assert property (p_port_wo) else $error("data port read not zero");
    property p_ctl_rsvd;
        rd_ctl |=> rdata[31:17] == 15'h0 && rdata[15:5] == 11'h0;
    endproperty
    a_ctl_rsvd: assert property (p_ctl_rsvd) else $error("reserved control bits set");
    property p_busy_set;
        rd_ctl && cnt > 6'h01 |=> rdata[CE_B_BUSY];
    endproperty
    a_busy_set: assert property (p_busy_set) else $error("busy low while computing");
    property p_busy_clr;
        rd_ctl && cnt == 6'h00 && $past(cnt) == 6'h00 |=> !rdata[CE_B_BUSY];
    endproperty
    a_busy_clr: assert property (p_busy_clr) else $error("busy high while idle");
    property p_dma_gate;
        dma_req |-> gate || $past(gate);
    endproperty
    a_dma_gate: assert property (p_dma_gate) else $error("dma request without enables");
    property p_quiet;
        s_dw |=> s_quiet;
    endproperty
    a_quiet: assert property (p_quiet) else $error("dma request during computation");
    property p_req_back;
        s_dw ##0 (size == CE_SZ_WORD && dma_q) |-> ##[33:40] dma_req;
    endproperty
    a_req_back: assert property (p_req_back) else $error("no new request after word");
endmodule

// >>> dv/tb_top.sv
// Testbench: software on AHB-Lite drives the controller, engine on the link.
// Assumes a zero-wait slave and both ends joined by one link interface.
`timescale 1ns/10ps
module tb_top
    import ce_pkg::*;
;
    logic        hclk;
    logic        hresetn;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         dma_irq;
    int          errors;
    int          checked;
    logic [31:0] q;

    ce_link_if ce_link_if_inst ();
    ce_engine ce_engine_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .link(ce_link_if_inst));
    ce_ctrl ce_ctrl_inst (.hclk(hclk), .hresetn(hresetn), .ce(1'h1), .hsel(1'h1), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .dma_irq(dma_irq), .link(ce_link_if_inst));
    ce_link_props ce_link_props_inst (.hclk(hclk), .hresetn(hresetn), .req(ce_link_if_inst.req),
        .wr(ce_link_if_inst.wr), .idx(ce_link_if_inst.idx), .size(ce_link_if_inst.size),
        .wdata(ce_link_if_inst.wdata), .rdata(ce_link_if_inst.rdata), .ack(ce_link_if_inst.ack),
        .dma_req(ce_link_if_inst.dma_req));

    initial begin
        hclk = 1'h0;
        forever #2.5 hclk = ~hclk;
    end
    ////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (errors == 0 && checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // Reference bit-serial CRC; bytes reordered first, then bits
    function automatic logic [31:0] crc_f(input logic [31:0] c, d, input int nb, input logic m, s,
                                          input logic [31:0] p);
        int j;
        int k;
        int bi;
        logic b;
        for (j = 0; j < nb; j++) begin
            for (k = 0; k < 8; k++) begin
                bi = (s ? nb - 1 - j : j) * 8 + (m ? 7 - k : k);
                b = (m ? c[31] : c[0]) ^ d[bi];
                c = m ? c << 1 : c >> 1;
                c = b ? c ^ p : c;
            end
        end
        return c;
    endfunction
    ////////////////////////////////////////////////////////////////
    // Bounded wait for hready; a hang ends the run
    task automatic rdy();
        int n;
        for (n = 0; n < 50; n++) begin
            @(posedge hclk);
            if (hreadyout === 1'h1) return;
        end
        cmp("hready", 32'h1, 32'h0);
        complete_run();
    endtask
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        rdy();
        htrans <= 2'h0;
        hwdata <= d;
        rdy();
        r = hrdata;
        cmp("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic hw(input logic [7:0] a, input logic [31:0] d);
        ahb(1'h1, a, d, q);
    endtask
    task automatic hr(input logic [7:0] a, output logic [31:0] r);
        ahb(1'h0, a, 32'h0, r);
    endtask
    // One engine register access through the controller
    task automatic eng(input logic w, input logic [1:0] i, s, input logic [31:0] d, output logic [31:0] r);
        int n;
        hw(CE_H_WDAT, d);
        hw(CE_H_CMD, {23'h0, w, 2'h0, s, i, 2'h0});
        for (n = 0; n < 20; n++) begin
            hr(CE_H_STAT, r);
            if (r[0] === 1'h0) break;
        end
        cmp("pending", 32'h0, {31'h0, r[0]});
        if (r[0] !== 1'h0) complete_run();
        hr(CE_H_RDAT, r);
    endtask
    task automatic ew(input logic [1:0] i, s, input logic [31:0] d);
        logic [31:0] r;
        eng(1'h1, i, s, d, r);
    endtask
    task automatic er(input logic [1:0] i, output logic [31:0] r);
        eng(1'h0, i, CE_SZ_WORD, 32'h0, r);
    endtask
    task automatic idle();
        int n;
        for (n = 0; n < 40; n++) begin
            er(2'h0, q);
            if (q[CE_B_BUSY] === 1'h0) return;
        end
        cmp("busy", 32'h0, q);
        complete_run();
    endtask
    ////////////////////////////////////////////////////////////////
    task automatic t_reset();
        hresetn <= 1'h0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'h1;
        er(2'h0, q);
        cmp("ctrl", CE_ZERO, q);
        er(2'h2, q);
        cmp("poly", CE_POLY_RST, q);
        er(2'h3, q);
        cmp("value", CE_ZERO, q);
        er(2'h1, q);
        cmp("data port", CE_ZERO, q);
        hr(8'h30, q);
        cmp("unmapped", CE_ZERO, q);
    endtask
    // Check string through word and byte views, refusals, output swap
    task automatic t_crc32();
        ew(2'h3, CE_SZ_WORD, 32'hFFFF_FFFF);
        ew(2'h0, CE_SZ_WORD, 32'h1);
        ew(2'h1, CE_SZ_WORD, 32'h3433_3231);
        er(2'h0, q);
        cmp("busy", 32'h1, {31'h0, q[CE_B_BUSY]});
        idle();
        ew(2'h1, CE_SZ_WORD, 32'h3837_3635);
        ew(2'h1, CE_SZ_WORD, 32'h0);
        idle();
        ew(2'h1, CE_SZ_BYTE, 32'hFFFF_FF39);
        idle();
        ew(2'h0, CE_SZ_WORD, 32'h10);
        er(2'h3, q);
        cmp("swapped", 32'hD9C6_0B34, q);
        ew(2'h0, CE_SZ_WORD, 32'h0);
        ew(2'h1, CE_SZ_WORD, 32'h1234_5678);
        er(2'h3, q);
        cmp("value", 32'h340B_C6D9, q);
    endtask
    // All four bit and byte orders with halfword then byte
    task automatic t_modes();
        int m;
        logic [31:0] p;
        logic [31:0] s;
        logic [31:0] e;
        for (m = 0; m < 4; m++) begin
            p = m[0] ? 32'h1021_0000 : 32'h0000_8408;
            s = m[0] ? 32'hA5A5_0000 : 32'h0000_A5A5;
            e = crc_f(crc_f(s, 32'hC3E1, 2, m[0], m[1], p), 32'h7E, 1, m[0], m[1], p);
            ew(2'h0, CE_SZ_WORD, {28'h0, m[1], m[0], 2'h0});
            ew(2'h2, CE_SZ_WORD, p);
            er(2'h2, q);
            cmp("poly", p, q);
            ew(2'h3, CE_SZ_WORD, s);
            ew(2'h0, CE_SZ_WORD, {28'h0, m[1], m[0], 2'h1});
            ew(2'h1, CE_SZ_HALF, 32'h0000_C3E1);
            idle();
            ew(2'h1, CE_SZ_BYTE, 32'h0000_007E);
            idle();
            er(2'h3, q);
            cmp("mode value", e, q);
        end
    endtask
    // Two words by the channel, done flag and interrupt
    task automatic t_dma();
        int n;
        ew(2'h0, CE_SZ_WORD, 32'h0);
        ew(2'h2, CE_SZ_WORD, CE_POLY_RST);
        ew(2'h3, CE_SZ_WORD, 32'hFFFF_FFFF);
        hw(CE_H_MEM, 32'h3433_3231);
        hw(CE_H_MEM + 8'h04, 32'h3837_3635);
        ew(2'h0, CE_SZ_WORD, 32'h1);
        hr(CE_H_STAT, q);
        cmp("dma_req off", 32'h0, {31'h0, q[3]});
        ew(2'h0, CE_SZ_WORD, 32'h3);
        hr(CE_H_STAT, q);
        cmp("dma_req on", 32'h1, {31'h0, q[3]});
        hw(CE_H_DMA, 32'h0000_020D);
        for (n = 0; n < 300; n++) begin
            hr(CE_H_STAT, q);
            if (q[1] === 1'h1) break;
        end
        cmp("done", 32'h1, {31'h0, q[1]});
        if (q[1] !== 1'h1) complete_run();
        cmp("irq", 32'h1, {31'h0, dma_irq});
        hw(CE_H_CLR, 32'h1);
        hr(CE_H_STAT, q);
        cmp("irq off", 32'h0, {31'h0, dma_irq});
        ew(2'h0, CE_SZ_WORD, 32'h0);
        er(2'h3, q);
        cmp("dma value", crc_f(crc_f(32'hFFFF_FFFF, 32'h3433_3231, 4, 1'h0, 1'h0, CE_POLY_RST),
            32'h3837_3635, 4, 1'h0, 1'h0, CE_POLY_RST), q);
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        errors = 0;
        checked = 0;
        htrans = 2'h0;
        haddr = 8'h00;
        hwrite = 1'h0;
        hwdata = 32'h0;
        hresetn = 1'h0;
        t_reset();
        t_crc32();
        t_modes();
        t_dma();
        t_reset();
        complete_run();
    end
endmodule

// >>> hw/ce_ctrl.sv
// Controller end: AHB-Lite slave for software, plus a simple
// memory-to-engine DMA channel with a done flag and interrupt.
// Assumes single word transfers; the slave is always zero-wait.
//
// The AHB-Lite register port was left to the implementer.
`timescale 1ns/10ps
module ce_ctrl
    import ce_pkg::*;
#(
    parameter int DEPTH = 8
) (
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic        hready,
    input  wire logic [31:0] hwdata,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // DMA channel interrupt
    output logic             dma_irq,
    // Link to engine
    ce_link_if.ctl           link
);
    localparam int AW = $clog2(DEPTH);
    logic [31:0] mem [DEPTH];
    logic [7:0]  d_addr;
    logic        d_wr;
    logic [31:0] cmd_wdat;
    logic [31:0] cmd_rdat;
    logic        sw_go;
    logic        pend;
    logic        from_dma;
    logic        dma_go;
    logic [1:0]  dma_wd;
    logic        dma_ie;
    logic [3:0]  dma_cnt;
    logic [AW-1:0] dma_ptr;
    logic        done;
    logic        l_req;
    logic        l_wr;
    logic [1:0]  l_idx;
    logic [1:0]  l_size;
    logic [31:0] l_wdata;
    logic        sw_wr;
    logic [1:0]  sw_idx;
    logic [1:0]  sw_size;

    ////////////////////////////////////////////////////////////////
    // AHB decode; address phase only when hready is seen high
    wire        a_ok   = hsel && htrans[1] && hready;
    wire        w_cmd  = d_wr && (d_addr == CE_H_CMD);
    wire        w_wdat = d_wr && (d_addr == CE_H_WDAT);
    wire        w_dma  = d_wr && (d_addr == CE_H_DMA);
    wire        w_clr  = d_wr && (d_addr == CE_H_CLR) && hwdata[0];
    wire        w_mem  = d_wr && (d_addr[7:6] == CE_H_MEM[7:6]);
    // Pending also covers the cycle in which the request is on the link
    wire [31:0] stat   = {28'h0, link.dma_req, dma_irq, done, pend | sw_go | l_req};
    wire [31:0] rd_mux = (haddr == CE_H_WDAT) ? cmd_wdat
                       : (haddr == CE_H_RDAT) ? cmd_rdat
                       : (haddr == CE_H_STAT) ? stat
                       : (haddr == CE_H_DMA)  ? {20'h0, dma_cnt, 4'h0, dma_ie, dma_wd, dma_go}
                       : (haddr[7:6] == CE_H_MEM[7:6]) ? mem[haddr[AW+1:2]]
                       : CE_ZERO;

    ////////////////////////////////////////////////////////////////
    // Link issue: software first, then DMA when the engine asks
    wire idle     = !pend && !l_req;
    wire iss_sw   = idle && sw_go;
    wire iss_dma  = idle && !sw_go && dma_go && (dma_cnt != 4'h0) && link.dma_req;
    // Last word absorbed once the engine asks again, i.e. busy fell
    wire fin_dma  = idle && dma_go && (dma_cnt == 4'h0) && link.dma_req;

    ////////////////////////////////////////////////////////////////
    // AHB data phase capture and registered read data
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            d_addr    <= 8'h00;
            d_wr      <= 1'b0;
            hrdata    <= CE_ZERO;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            d_wr   <= a_ok && hwrite;
            d_addr <= haddr;
            hrdata <= rd_mux;
        end
    end

    // Source memory for the DMA channel
    always_ff @(posedge hclk) begin
        if (ce && w_mem) begin
            mem[d_addr[AW+1:2]] <= hwdata;
        end
    end

    ////////////////////////////////////////////////////////////////
    // Command and DMA registers; a set of done beats a clear
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cmd_wdat <= CE_ZERO;
            cmd_rdat <= CE_ZERO;
            sw_go    <= 1'b0;
            pend     <= 1'b0;
            from_dma <= 1'b0;
            dma_go   <= 1'b0;
            dma_wd   <= CE_SZ_BYTE;
            dma_ie   <= 1'b0;
            dma_cnt  <= 4'h0;
            dma_ptr  <= '0;
            done     <= 1'b0;
            dma_irq  <= 1'b0;
        end else if (ce) begin
            if (w_wdat) begin
                cmd_wdat <= hwdata;
            end
            if (w_cmd) begin
                sw_go <= 1'b1;
            end else if (iss_sw) begin
                sw_go <= 1'b0;
            end
            if (w_dma) begin
                dma_go  <= hwdata[CE_D_GO];
                dma_wd  <= hwdata[CE_D_WD +: 2];
                dma_ie  <= hwdata[CE_D_IE];
                dma_cnt <= hwdata[CE_D_CNT +: 4];
                dma_ptr <= '0;
            end else if (iss_dma) begin
                dma_cnt <= dma_cnt - 4'h1;
                dma_ptr <= dma_ptr + 1'b1;
            end else if (fin_dma) begin
                dma_go <= 1'b0;
            end
            if (l_req) begin
                pend <= 1'b1;
            end else if (link.ack) begin
                pend <= 1'b0;
                if (!from_dma) begin
                    cmd_rdat <= link.rdata;
                end
            end
            if (iss_sw || iss_dma) begin
                from_dma <= iss_dma;
            end
            if (fin_dma) begin
                done <= 1'b1;
            end else if (w_clr) begin
                done <= 1'b0;
            end
            dma_irq <= (done || fin_dma) && dma_ie && !(w_clr && !fin_dma);
        end
    end

    ////////////////////////////////////////////////////////////////
    // Link request, one-cycle pulse with held fields
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            l_req   <= 1'b0;
            l_wr    <= 1'b0;
            l_idx   <= 2'h0;
            l_size  <= CE_SZ_WORD;
            l_wdata <= CE_ZERO;
        end else if (ce) begin
            l_req <= iss_sw || iss_dma;
            if (iss_sw) begin
                l_wr    <= sw_wr;
                l_idx   <= sw_idx;
                l_size  <= sw_size;
                l_wdata <= cmd_wdat;
            end else if (iss_dma) begin
                l_wr    <= 1'b1;
                l_idx   <= CE_OFF_DATA[3:2];
                l_size  <= dma_wd;
                l_wdata <= mem[dma_ptr];
            end
        end
    end

    // Latched command fields from the last write to the command register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sw_wr   <= 1'b0;
            sw_idx  <= 2'h0;
            sw_size <= CE_SZ_WORD;
        end else if (ce && w_cmd) begin
            sw_wr   <= hwdata[CE_C_WR];
            sw_idx  <= hwdata[CE_C_IDX +: 2];
            sw_size <= hwdata[CE_C_SZ +: 2];
        end
    end

    assign link.req   = l_req;
    assign link.wr    = l_wr;
    assign link.idx   = l_idx;
    assign link.size  = l_size;
    assign link.wdata = l_wdata;
endmodule

// >>> hw/ce_engine.sv
// CRC engine: register port on the link, bit-serial core inside.
// Assumes the controller keeps one access open at a time and waits
// for ack before the next; registers answer one clock after req.
`timescale 1ns/10ps
module ce_engine
    import ce_pkg::*;
#(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic ce,
    // Link to controller
    ce_link_if.dev    link
);
    // Control fields
    logic         en;
    logic         dma_en;
    logic         msb;
    logic         swap_in;
    logic         swap_out;
    logic [W-1:0] poly;
    logic [W-1:0] crc;
    logic         busy;
    // Link outputs
    logic [31:0]  rdata;
    logic         ack;
    logic         dma_req;

    ////////////////////////////////////////////////////////////////
    // Reverse the byte order of the low 1, 2 or 4 bytes
    function automatic logic [31:0] swap_bytes(input logic [31:0] d,
                                               input logic [1:0]  sz);
        logic [31:0] r;
        r = d;
        case (sz)
            CE_SZ_HALF: r = {16'h0000, d[7:0], d[15:8]};
            CE_SZ_WORD: r = {d[7:0], d[15:8], d[23:16], d[31:24]};
            default:    r = d;
        endcase
        return r;
    endfunction

    // Mirror the bits inside each byte
    function automatic logic [31:0] mirror_bytes(input logic [31:0] d);
        logic [31:0] r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r[i] = d[(i & ~7) + 7 - (i & 7)];
        end
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////
    // Address decode of the current request
    wire [3:0] off    = {link.idx, 2'h0};
    wire       hit_ct = link.req && (off == CE_OFF_CTRL);
    wire       hit_dt = link.req && (off == CE_OFF_DATA);
    wire       hit_pl = link.req && (off == CE_OFF_POLY);
    wire       hit_vl = link.req && (off == CE_OFF_VAL);
    wire       wr_ct  = hit_ct && link.wr;
    wire       wr_pl  = hit_pl && link.wr && !busy;
    wire       wr_vl  = hit_vl && link.wr && !busy;
    // A data write is only taken while enabled and idle
    wire       wr_dt  = hit_dt && link.wr && en && !busy;

    ////////////////////////////////////////////////////////////////
    // Input ordering: mask to width, swap bytes, then mirror bits
    wire [31:0] din_mask = (link.size == CE_SZ_BYTE) ? {24'h0, link.wdata[7:0]}
                         : (link.size == CE_SZ_HALF) ? {16'h0, link.wdata[15:0]}
                         : link.wdata;
    wire [31:0] din_ord  = swap_in ? swap_bytes(din_mask, link.size) : din_mask;
    wire [31:0] din_core = msb ? mirror_bytes(din_ord) : din_ord;
    // Bit count is eight times the byte count
    wire [5:0]  nbits    = (link.size == CE_SZ_BYTE) ? 6'h08
                         : (link.size == CE_SZ_HALF) ? 6'h10 : 6'h20;

    ////////////////////////////////////////////////////////////////
    // Presented value and register read mux
    wire [31:0] val_out  = swap_out ? swap_bytes(crc, CE_SZ_WORD) : crc;
    wire [31:0] ctrl_rd  = ({31'h0, en}       << CE_B_EN)
                         | ({31'h0, dma_en}   << CE_B_DMA)
                         | ({31'h0, msb}      << CE_B_MSB)
                         | ({31'h0, swap_in}  << CE_B_SWIN)
                         | ({31'h0, swap_out} << CE_B_SWOUT)
                         | ({31'h0, busy}     << CE_B_BUSY);
    wire [31:0] rd_mux   = hit_ct ? ctrl_rd
                         : hit_pl ? poly
                         : hit_vl ? val_out
                         : CE_ZERO;
    // Request goes out only when enabled, idle and no access in flight
    wire        next_dma = en && dma_en && !busy && !link.req;

    ////////////////////////////////////////////////////////////////
    // Serial core; the final value stays held after disabling
    ce_lfsr #(
        .W        (W)
    ) u_lfsr (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .ce       (ce),
        .load     (wr_vl),
        .load_val (link.wdata),
        .start    (wr_dt),
        .data     (din_core),
        .nbits    (nbits),
        .msb      (msb),
        .poly     (poly),
        .crc      (crc),
        .busy     (busy)
    );

    ////////////////////////////////////////////////////////////////
    // Control and polynomial registers; all resets share hresetn
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en       <= 1'b0;
            dma_en   <= 1'b0;
            msb      <= 1'b0;
            swap_in  <= 1'b0;
            swap_out <= 1'b0;
            poly     <= CE_POLY_RST;
        end else if (ce) begin
            if (wr_ct) begin
                en       <= link.wdata[CE_B_EN];
                dma_en   <= link.wdata[CE_B_DMA];
                msb      <= link.wdata[CE_B_MSB];
                swap_in  <= link.wdata[CE_B_SWIN];
                swap_out <= link.wdata[CE_B_SWOUT];
            end
            if (wr_pl) begin
                poly <= link.wdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // Link answer, one clock after every request
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata   <= CE_ZERO;
            ack     <= 1'b0;
            dma_req <= 1'b0;
        end else if (ce) begin
            ack     <= link.req;
            rdata   <= rd_mux;
            dma_req <= next_dma;
        end
    end

    assign link.rdata   = rdata;
    assign link.ack     = ack;
    assign link.dma_req = dma_req;
endmodule

// >>> hw/ce_lfsr.sv
// Bit-serial CRC shift register, one input bit per clock.
// Assumes data is pre-ordered so that bit 0 is absorbed first.
`timescale 1ns/10ps
module ce_lfsr
    import ce_pkg::*;
#(
    parameter int W = 32
) (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    input  wire logic         ce,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] load_val,
    input  wire logic         start,
    input  wire logic [W-1:0] data,
    input  wire logic [5:0]   nbits,
    input  wire logic         msb,
    input  wire logic [W-1:0] poly,
    // State
    output logic      [W-1:0] crc,
    output logic              busy
);
    logic [W-1:0] sh;
    logic [5:0]   cnt;
    logic [W-1:0] next_crc;
    wire          fb_lsb = crc[0] ^ sh[0];
    wire          fb_msb = crc[W-1] ^ sh[0];

    ////////////////////////////////////////////////////////////////
    // Reflected form shifts right, left-justified form shifts left
    assign next_crc = msb ? ((crc << 1) ^ (fb_msb ? poly : '0))
                          : ((crc >> 1) ^ (fb_lsb ? poly : '0));
    assign busy     = (cnt != 6'h00);

    ////////////////////////////////////////////////////////////////
    // One bit absorbed per enabled clock until the count runs out
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            crc <= '0;
            sh  <= '0;
            cnt <= 6'h00;
        end else if (ce) begin
            if (load) begin
                crc <= load_val;
            end else if (start) begin
                sh  <= data;
                cnt <= nbits;
            end else if (busy) begin
                crc <= next_crc;
                sh  <= sh >> 1;
                cnt <= cnt - 6'h01;
            end
        end
    end
endmodule

// >>> hw/ce_link_if.sv
// Link between the CRC engine and its controller.
// Assumes both ends run on the same clock; all signals are levels
// except req and ack, which are one-cycle pulses.
`timescale 1ns/10ps
interface ce_link_if;
    logic        req;
    logic        wr;
    logic [1:0]  idx;
    logic [1:0]  size;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        ack;
    logic        dma_req;

    // Engine end
    modport dev (input req, wr, idx, size, wdata, output rdata, ack, dma_req);
    // Controller end
    modport ctl (output req, wr, idx, size, wdata, input rdata, ack, dma_req);
endinterface

// >>> hw/ce_pkg.sv
// Shared constants for the CRC engine and its controller.
// Assumes one 200 MHz clock and active-low async reset everywhere except the DMA source memory.
package ce_pkg;
    // Device register offsets (byte addresses)
    localparam logic [3:0] CE_OFF_CTRL = 4'h0;
    localparam logic [3:0] CE_OFF_DATA = 4'h4;
    localparam logic [3:0] CE_OFF_POLY = 4'h8;
    localparam logic [3:0] CE_OFF_VAL  = 4'hC;
    // Control fields
    localparam int CE_B_EN    = 0;
    localparam int CE_B_DMA   = 1;
    localparam int CE_B_MSB   = 2;
    localparam int CE_B_SWIN  = 3;
    localparam int CE_B_SWOUT = 4;
    localparam int CE_B_BUSY  = 16;
    // Reset values
    localparam logic [31:0] CE_POLY_RST = 32'hEDB88320;
    localparam logic [31:0] CE_ZERO     = 32'h0000_0000;
    // Access sizes, also DMA destination widths
    localparam logic [1:0] CE_SZ_BYTE = 2'h0;
    localparam logic [1:0] CE_SZ_HALF = 2'h1;
    localparam logic [1:0] CE_SZ_WORD = 2'h2;
    // Controller registers on AHB
    localparam logic [7:0] CE_H_CMD   = 8'h00;
    localparam logic [7:0] CE_H_WDAT  = 8'h04;
    localparam logic [7:0] CE_H_RDAT  = 8'h08;
    localparam logic [7:0] CE_H_STAT  = 8'h0C;
    localparam logic [7:0] CE_H_DMA   = 8'h10;
    localparam logic [7:0] CE_H_CLR   = 8'h14;
    localparam logic [7:0] CE_H_MEM   = 8'h40;
    // Controller command and DMA fields
    localparam int CE_C_IDX = 2;
    localparam int CE_C_SZ  = 4;
    localparam int CE_C_WR  = 8;
    localparam int CE_D_GO  = 0;
    localparam int CE_D_WD  = 1;
    localparam int CE_D_IE  = 3;
    localparam int CE_D_CNT = 8;
endpackage
